//--- rtl/sra_dev.sv
// module: slave end giving the master access to registers and the fifo
// Contract
// R1: slave only, no clock or arbitration
// R2: never stretches the clock
// R3: general call address is ignored
// R4: device identification query not answered
// R5: high-speed mode not supported
// R6: rates up to 400 kbit/s, 1 Mbit/s
// R7: spike filters on both lines when selected
// R8: data changes only while clock low
// R9: start and stop detected on data edges
// R10: busy from start to stop, restart alike
// R11: msb first, one acknowledge per byte
// R12: transmitter releases, receiver pulls acknowledge low
// R13: last read byte unacknowledged, slave releases
// R14: address 01010 plus two selectable low bits
// R15: write: address, register byte, data bytes
// R16: fifo register write keeps fifo target
// R17: read: register byte frame, then read address
// R18: read returns pointer register, then increments
// R19: fifo pointer never increments
// R20: short link: fast protocol, keeper, no stretch
// R21: short link clock driven push-pull
// R22: short link pin strap upper bit zero
// R23: short link: nobody drives data while clock high; the master still drives it through start, stop and idle
// R24: acknowledge own address and received bytes
`timescale 1ns/1ns
module sra_dev
   import sra_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   sra_if.dev bus,
   input wire logic [1:0] adr_pin,
   input wire logic [1:0] adr_cfg,
   input wire logic adr_use_pin,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   output logic bus_busy
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACKA,
      ST_RX,
      ST_ACKW,
      ST_TX,
      ST_ACKR
   } sra_dev_state_t;

   typedef struct packed {
      sra_dev_state_t st;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic rw;
      logic first;
      logic ack_ok;
      logic busy;
      logic drv;
      logic dval;
      logic wr;
      logic rd;
      logic [7:0] ptr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic scl_p;
      logic sda_p;
      logic [1:0] ap1;
      logic [1:0] ap2;
      logic sr1;
      logic sr2;
   } sra_dev_st_t;

   sra_dev_st_t q;
   sra_dev_st_t d;
   logic scl_f;
   logic sda_f;
   logic [1:0] adr_lo;
   logic [7:0] ptr_nx;
   logic rise;
   logic fall;

   // both lines pass a synchroniser; the spike filter is on for the bus
   sra_pin_filt u_scl_filt (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin(bus.scl),
      .filt_en(!q.sr2), // [R7]
      .lvl(scl_f)
   );

   sra_pin_filt u_sda_filt (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin(bus.sda),
      .filt_en(!q.sr2), // [R7]
      .lvl(sda_f)
   );

   // low address bits: strap pins or configuration value
   assign adr_lo = !adr_use_pin ? adr_cfg :
      (q.sr2 ? {1'h0, q.ap2[0]} : q.ap2); // [R14] [R22]

   // pointer advances except on the fifo register
   assign ptr_nx = (q.ptr == FIFO_REG) ? q.ptr : q.ptr + 8'h01; // [R19]

   // clock edges seen on the filtered line; data sampled on the rise
   assign rise = !q.scl_p && scl_f; // [R6]
   assign fall = q.scl_p && !scl_f;

   // next state of the byte engine
   always_comb begin
      d = q;
      d.wr = 1'h0;
      d.rd = 1'h0;
      d.ap1 = adr_pin;
      d.ap2 = q.ap1;
      d.sr1 = bus.short_reach;
      d.sr2 = q.sr1;
      d.scl_p = scl_f;
      d.sda_p = sda_f;
      // register data arrives in the read strobe cycle; msb goes out first
      if (q.rd) begin
         d.sh = {reg_rdata[6:0], 1'h0};
         d.dval = reg_rdata[7]; // [R11]
         d.drv = 1'h1;
      end
      if (q.scl_p && scl_f && q.sda_p && !sda_f) begin
         // start or repeated start: same handling, bus busy
         d.st = ST_ADDR; // [R9] [R10]
         d.busy = 1'h1;
         d.cnt = 4'h0;
         d.drv = 1'h0;
      end else if (q.scl_p && scl_f && !q.sda_p && sda_f) begin
         // stop frees the bus
         d.st = ST_IDLE; // [R9] [R10]
         d.busy = 1'h0;
         d.drv = 1'h0;
      end else if (rise) begin
         case (q.st)
            ST_ADDR, ST_RX: begin
               d.sh = {q.sh[6:0], sda_f}; // [R11]
               d.cnt = q.cnt + 4'h1;
            end
            ST_TX: begin
               d.cnt = q.cnt + 4'h1;
            end
            ST_ACKR: begin
               d.ack_ok = !sda_f;
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         case (q.st)
            ST_ADDR: begin
               if (q.cnt == BYTE_BITS) begin
                  // general call, id query and high-speed codes never match
                  if (q.sh[7:3] == ADDR_FIXED && q.sh[2:1] == adr_lo) begin // [R3] [R4] [R5]
                     d.st = ST_ACKA;
                     d.rw = q.sh[0];
                     d.first = !q.sh[0];
                     d.drv = 1'h1; // [R24]
                     d.dval = 1'h0; // [R12]
                  end else begin
                     d.st = ST_IDLE; // [R24]
                  end
               end
            end
            ST_ACKA: begin
               d.drv = 1'h0;
               d.cnt = 4'h0;
               if (q.rw) begin
                  d.st = ST_TX;
                  d.rd = 1'h1; // [R18]
                  d.addr = q.ptr;
               end else begin
                  d.st = ST_RX;
               end
            end
            ST_RX: begin
               if (q.cnt == BYTE_BITS) begin
                  d.st = ST_ACKW;
                  d.drv = 1'h1; // [R24]
                  d.dval = 1'h0; // [R12]
                  if (q.first) begin
                     d.ptr = q.sh;
                     d.first = 1'h0;
                  end else begin
                     d.wr = 1'h1;
                     d.addr = q.ptr;
                     d.wdata = q.sh;
                     d.ptr = ptr_nx; // [R16]
                  end
               end
            end
            ST_ACKW: begin
               d.st = ST_RX;
               d.drv = 1'h0;
               d.cnt = 4'h0;
            end
            ST_TX: begin
               if (q.cnt == BYTE_BITS) begin
                  // release for the master's acknowledge
                  d.st = ST_ACKR;
                  d.drv = 1'h0; // [R12]
                  d.ptr = ptr_nx; // [R18] [R19]
               end else begin
                  d.dval = q.sh[7]; // [R8] [R11]
                  d.sh = {q.sh[6:0], 1'h0};
               end
            end
            ST_ACKR: begin
               // no acknowledge: stay released until stop or restart
               if (q.ack_ok) begin
                  d.st = ST_TX;
                  d.cnt = 4'h0;
                  d.rd = 1'h1;
                  d.addr = q.ptr;
               end else begin
                  d.st = ST_IDLE; // [R13]
               end
            end
            default: begin
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '{ST_IDLE, 8'h00, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1,
            1'h0, 1'h0, PTR_RESET, 8'h00, 8'h00, 1'h1, 1'h1, 2'h0, 2'h0,
            1'h0, 1'h0};
      end else begin
         q <= d;
      end
   end

   // data pin: open drain on the bus; short link drives only while clock low
   assign bus.s_sda_o = q.dval;
   assign bus.s_sda_oe_n = q.sr2 ? !(q.drv && !scl_f) : // [R20] [R23]
      !(q.drv && !q.dval); // [R12]
   // no clock output at all: never stretches, never generates the clock [R1] [R2]

   assign reg_wr = q.wr;
   assign reg_rd = q.rd;
   assign reg_addr = q.addr;
   assign reg_wdata = q.wdata;
   assign bus_busy = q.busy; // [R10]
endmodule // sra_dev

//--- rtl/sra_pkg.sv
// package: shared constants of the register access two-wire link
package sra_pkg;
   localparam int SYS_CLK_KHZ = 125000;
   // spike suppression width and its cycle count
   localparam int SPIKE_NS = 50;
   localparam int SPIKE_CYC = (SPIKE_NS * SYS_CLK_KHZ + 999999) / 1000000;
   localparam logic [2:0] SPIKE_LAST = 3'(SPIKE_CYC - 1);
   // bit rates and the quarter-bit counts of the master's divider
   localparam int RATE_STD_KBPS = 100;
   localparam int RATE_FAST_KBPS = 400;
   localparam int RATE_FPLUS_KBPS = 1000;
   localparam int RATE_SHORT_KBPS = 5000;
   localparam logic [8:0] QTR_STD =
      9'((SYS_CLK_KHZ + 4 * RATE_STD_KBPS - 1) / (4 * RATE_STD_KBPS));
   localparam logic [8:0] QTR_FAST =
      9'((SYS_CLK_KHZ + 4 * RATE_FAST_KBPS - 1) / (4 * RATE_FAST_KBPS));
   localparam logic [8:0] QTR_FPLUS =
      9'((SYS_CLK_KHZ + 4 * RATE_FPLUS_KBPS - 1) / (4 * RATE_FPLUS_KBPS));
   localparam logic [8:0] QTR_SHORT =
      9'((SYS_CLK_KHZ + 4 * RATE_SHORT_KBPS - 1) / (4 * RATE_SHORT_KBPS));
   localparam logic [1:0] RATE_SEL_STD = 2'h0;
   localparam logic [1:0] RATE_SEL_FAST = 2'h1;
   localparam logic [1:0] RATE_SEL_FPLUS = 2'h2;
   localparam logic [1:0] RATE_SEL_SHORT = 2'h3;
   // slave address and register pointer
   localparam logic [4:0] ADDR_FIXED = 5'h0A;
   localparam logic [7:0] FIFO_REG = 8'h05;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   typedef enum logic [1:0] {SRA_CMD_START, SRA_CMD_STOP, SRA_CMD_WRITE, SRA_CMD_READ} sra_cmd_t;
endpackage

//--- rtl/sra_if.sv
// interface: wires of the two-wire link and how they resolve
`timescale 1ns/1ns
interface sra_if;
   logic short_reach;
   logic scl_o;
   logic scl_oe_n;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic s_sda_o;
   logic s_sda_oe_n;
   logic scl;
   logic sda;
   logic keep = 1'h1;

   // bus keeper of the short-reach link; idle high when the link switches over
   always_latch begin
      if (short_reach && (!m_sda_oe_n || !s_sda_oe_n)) begin
         keep <= !m_sda_oe_n ? m_sda_o : s_sda_o;
      end
   end

   // pull-ups on the open-drain bus, push-pull plus keeper on the short link
   assign scl = scl_oe_n | scl_o;
   assign sda = short_reach ?
      (!m_sda_oe_n ? m_sda_o : (!s_sda_oe_n ? s_sda_o : keep)) :
      !((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o));

   modport dev (input scl, input sda, input short_reach, output s_sda_o, output s_sda_oe_n);
   modport host (input sda, input short_reach, output scl_o, output scl_oe_n,
      output m_sda_o, output m_sda_oe_n);
endinterface

//--- rtl/sra_pin_filt.sv
// module: two-flop synchroniser with spike filter for one link pin
`timescale 1ns/1ns
module sra_pin_filt
   import sra_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic pin,
   input wire logic filt_en,
   output logic lvl
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic lvl;
      logic [2:0] cnt;
   } sra_filt_st_t;

   sra_filt_st_t q;
   sra_filt_st_t d;

   // a change of the synchronised level must persist before it passes
   always_comb begin
      d = q;
      d.s1 = pin;
      d.s2 = q.s1;
      if (q.s2 == q.lvl) begin
         d.cnt = 3'h0;
      end else if (!filt_en || q.cnt == SPIKE_LAST) begin
         d.lvl = q.s2;
         d.cnt = 3'h0;
      end else begin
         d.cnt = q.cnt + 3'h1;
      end
   end

   // idle lines are high
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '{1'h1, 1'h1, 1'h1, 3'h0};
      end else begin
         q <= d;
      end
   end

   assign lvl = q.lvl;
endmodule // sra_pin_filt

//--- rtl/sra_host.sv
// module: master end issuing start, stop and byte commands on the link
`timescale 1ns/1ns
module sra_host
   import sra_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   sra_if.host bus,
   input wire logic [1:0] rate_sel,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire sra_cmd_t cmd,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_last,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_ack
);
   typedef enum logic [2:0] {H_IDLE, H_HOLD, H_START, H_STOP, H_BIT} sra_host_state_t;

   typedef struct packed {
      sra_host_state_t st;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic rd;
      logic last;
      logic scl_v;
      logic sda_v;
      logic own;
      logic rsp_v;
      logic [7:0] rsp_d;
      logic rsp_ack;
      logic [8:0] qc;
      logic sr1;
      logic sr2;
   } sra_host_st_t;

   sra_host_st_t q;
   sra_host_st_t d;
   logic sda_f;
   logic tick;
   logic [8:0] qlen;

   sra_pin_filt u_sda_filt (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin(bus.sda),
      .filt_en(!q.sr2),
      .lvl(sda_f)
   );

   // quarter-bit length caps the bit rate
   always_comb begin
      case (rate_sel)
         RATE_SEL_STD: qlen = QTR_STD;
         RATE_SEL_FAST: qlen = QTR_FAST; // [R6]
         RATE_SEL_FPLUS: qlen = QTR_FPLUS; // [R6]
         default: qlen = QTR_SHORT; // [R20]
      endcase
   end

   assign tick = q.qc == 9'h000;
   assign cmd_ready = q.st == H_IDLE || q.st == H_HOLD;

   // next state of the bit engine
   always_comb begin
      d = q;
      d.rsp_v = 1'h0;
      d.sr1 = bus.short_reach;
      d.sr2 = q.sr1;
      d.qc = tick ? qlen - 9'h001 : q.qc - 9'h001;
      if (cmd_valid && cmd_ready) begin
         d.ph = 2'h0;
         case (cmd)
            SRA_CMD_START: d.st = H_START;
            SRA_CMD_STOP: d.st = (q.st == H_HOLD) ? H_STOP : q.st;
            default: begin
               // address bytes carry the direction bit in bit 0
               if (q.st == H_HOLD) begin
                  d.st = H_BIT; // [R15] [R17]
                  d.bitn = 4'h0;
                  d.rd = cmd == SRA_CMD_READ;
                  d.sh = cmd_data;
                  d.last = cmd_last;
               end
            end
         endcase
      end else if (tick) begin
         d.ph = q.ph + 2'h1;
         case (q.st)
            H_START: begin
               case (q.ph)
                  2'h0: begin
                     d.sda_v = 1'h1;
                     d.own = 1'h1;
                  end
                  2'h1: d.scl_v = 1'h1;
                  2'h2: d.sda_v = 1'h0; // [R9]
                  default: begin
                     d.scl_v = 1'h0;
                     d.st = H_HOLD;
                  end
               endcase
            end
            H_STOP: begin
               case (q.ph)
                  2'h0: begin
                     d.sda_v = 1'h0;
                     d.own = 1'h1;
                  end
                  2'h1: d.scl_v = 1'h1;
                  2'h2: d.sda_v = 1'h1; // [R9]
                  default: d.st = H_IDLE; // [R23]
               endcase
            end
            H_BIT: begin
               case (q.ph)
                  2'h0: begin
                     // data or acknowledge placed while clock is low
                     if (q.bitn < BYTE_BITS) begin
                        d.own = !q.rd;
                        d.sda_v = q.rd ? 1'h1 : q.sh[7]; // [R8] [R11]
                     end else begin
                        d.own = q.rd; // [R12]
                        d.sda_v = q.last; // [R13]
                     end
                  end
                  2'h1: d.scl_v = 1'h1;
                  2'h2: begin
                     if (q.bitn < BYTE_BITS) begin
                        d.sh = {q.sh[6:0], sda_f}; // [R11]
                     end else begin
                        d.rsp_ack = !sda_f; // [R12]
                     end
                  end
                  default: begin
                     d.scl_v = 1'h0;
                     if (q.bitn == BYTE_BITS) begin
                        d.st = H_HOLD;
                        // open drain keeps the acknowledge level until the next bit starts
                        d.own = q.own && !q.sr2; // [R8] [R23]
                        d.rsp_v = 1'h1;
                        d.rsp_d = q.sh;
                     end else begin
                        d.bitn = q.bitn + 4'h1;
                        // short link: let go before the slave drives its acknowledge
                        if (q.sr2 && !q.rd && q.bitn == BYTE_BITS - 4'h1) begin
                           d.own = 1'h0; // [R23]
                        end
                     end
                  end
               endcase
            end
            default: begin
            end
         endcase
      end
   end

   // state register; idle has both lines high and the master owning data
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '{H_IDLE, 2'h0, 4'h0, 8'h00, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0,
            8'h00, 1'h0, 9'h000, 1'h0, 1'h0};
      end else begin
         q <= d;
      end
   end

   // short link: clock push-pull, data released while clock is high within a bit; start, stop and idle keep driving it
   assign bus.scl_o = q.scl_v;
   assign bus.scl_oe_n = q.sr2 ? 1'h0 : q.scl_v; // [R21]
   assign bus.m_sda_o = q.sda_v;
   assign bus.m_sda_oe_n = q.sr2 ?
      !(q.own && (!q.scl_v || q.st != H_BIT)) : // [R23]
      !(q.own && !q.sda_v);

   assign rsp_valid = q.rsp_v;
   assign rsp_data = q.rsp_d;
   assign rsp_ack = q.rsp_ack;
endmodule // sra_host

//--- tb/sra_properties.sv
// checker: protocol properties watched on the signals of the two-wire link
`timescale 1ns/1ns
module sra_properties (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic short_reach,
   input wire logic scl_oe_n,
   input wire logic m_sda_o,
   input wire logic m_sda_oe_n,
   input wire logic s_sda_o,
   input wire logic s_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q, sda_q, busy_q, first_q, rw_q;
   logic [3:0] cnt_q;
   logic start_c, stop_c, m_pull, s_pull;

   // line conditions and who pulls data low this cycle
   assign start_c = scl && scl_q && sda_q && !sda;
   assign stop_c = scl && scl_q && !sda_q && sda;
   assign m_pull = !m_sda_oe_n && !m_sda_o;
   assign s_pull = !s_sda_oe_n && !s_sda_o;

   // clock rises per byte, first byte flag and direction bit
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
         busy_q <= 1'h0;
         first_q <= 1'h0;
         rw_q <= 1'h0;
         cnt_q <= 4'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_c || stop_c) begin
            busy_q <= start_c;
            first_q <= 1'h1;
            cnt_q <= 4'h0;
         end else if (scl && !scl_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (first_q && cnt_q == 4'h7) rw_q <= sda; // direction bit ends the address
         end else if (!scl && scl_q && cnt_q == 4'h9) begin
            cnt_q <= 4'h0;
            first_q <= 1'h0;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_short_rise;
      short_reach && $rose(scl);
   endsequence
   sequence s_ack_fall;
      $fell(scl) && cnt_q == 4'h9;
   endsequence
   sequence s_frame_edge;
      stop_c || (start_c && busy_q);
   endsequence

   property p_scl_push;
      s_short_rise |-> !scl_oe_n;
   endproperty
   property p_no_contend;
      short_reach |-> m_sda_oe_n || s_sda_oe_n;
   endproperty
   property p_slave_release;
      s_short_rise |-> ##[0:6] s_sda_oe_n;
   endproperty
   property p_slave_stable;
      !short_reach && scl && $past(scl) |-> $stable(s_pull);
   endproperty
   property p_master_edge;
      !short_reach && $changed(scl) |-> $stable(m_pull);
   endproperty
   property p_ack_master_tx;
      s_ack_fall ##0 (first_q || !rw_q) |-> !$past(m_pull);
   endproperty
   property p_ack_slave_tx;
      s_ack_fall ##0 (!first_q && rw_q) |-> !$past(s_pull);
   endproperty
   property p_byte_frame;
      s_frame_edge |-> cnt_q == 4'h1;
   endproperty
   property p_idle_high;
      !busy_q && !start_c |-> sda && scl;
   endproperty

   a_scl_push: assert property (p_scl_push) else $error("short link clock rose undriven");
   a_no_contend: assert property (p_no_contend) else $error("both ends drive data");
   a_slave_release: assert property (p_slave_release) else $error("slave kept data in high");
   a_slave_stable: assert property (p_slave_stable) else $error("slave data moved in high");
   a_master_edge: assert property (p_master_edge) else $error("master data moved on clock edge");
   a_ack_master_tx: assert property (p_ack_master_tx) else $error("master held ack slot");
   a_ack_slave_tx: assert property (p_ack_slave_tx) else $error("slave held ack slot");
   a_byte_frame: assert property (p_byte_frame) else $error("byte not nine clocks");
   a_idle_high: assert property (p_idle_high) else $error("lines low while idle");

   c_read: cover property (s_ack_fall ##0 rw_q);
endmodule // sra_properties

//--- tb/tb.sv
// testbench: master end and slave end joined over the link, checked by queues
`timescale 1ns/1ns
module tb
   import sra_pkg::*;
;
   logic sys_clk, reset, short_reach, cmd_valid, cmd_last, adr_use_pin;
   logic cmd_ready, rsp_valid, rsp_ack, reg_wr, reg_rd, bus_busy;
   logic [1:0] rate_sel, adr_pin, adr_cfg;
   logic [7:0] cmd_data, rsp_data, reg_addr, reg_wdata, reg_rdata;
   sra_cmd_t cmd;
   logic [16:0] rsp_q[$];
   logic [16:0] reg_q[$];
   int miscompares = 0;
   int check_count = 0;

   sra_if bus_if();
   assign bus_if.short_reach = short_reach;

   sra_host sra_host_i (.sys_clk(sys_clk), .reset(reset), .bus(bus_if.host),
      .rate_sel(rate_sel), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
      .cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   sra_dev sra_dev_i (.sys_clk(sys_clk), .reset(reset), .bus(bus_if.dev),
      .adr_pin(adr_pin), .adr_cfg(adr_cfg), .adr_use_pin(adr_use_pin), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .bus_busy(bus_busy));
   sra_properties sra_props_i (.sys_clk(sys_clk), .reset(reset),
      .short_reach(bus_if.short_reach), .scl_oe_n(bus_if.scl_oe_n),
      .m_sda_o(bus_if.m_sda_o), .m_sda_oe_n(bus_if.m_sda_oe_n), .s_sda_o(bus_if.s_sda_o),
      .s_sda_oe_n(bus_if.s_sda_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));

   // register contents seen by the slave: a fixed scramble of the address
   function automatic logic [7:0] rdm(input logic [7:0] a);
      return {a[0], a[7:1]} ^ 8'hC3;
   endfunction
   assign reg_rdata = rdm(reg_addr);

   // low address bits the slave should answer to
   function automatic logic [1:0] lo();
      if (!adr_use_pin) return adr_cfg;
      return short_reach ? {1'b0, adr_pin[0]} : adr_pin;
   endfunction

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [16:0] exp, input logic [16:0] got);
      check_count++;
      if (exp !== got) begin
         miscompares++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // bounded wait for the master to take commands again, looked at on falling edges
   task automatic wait_rdy();
      int n;
      n = 0;
      while (cmd_ready !== 1'h1 && n < 20000) begin
         n++;
         @(negedge sys_clk);
      end
   endtask

   // request held from a falling edge through the rising edge that takes it
   task automatic cmd_do(input sra_cmd_t c, input logic [7:0] d, input logic last);
      @(negedge sys_clk);
      cmd_valid = 1'h1;
      cmd = c;
      cmd_data = d;
      cmd_last = last;
      wait_rdy();
      @(posedge sys_clk);
      @(negedge sys_clk);
      cmd_valid = 1'h0;
   endtask

   task automatic wbyte(input logic [7:0] d, input logic ack);
      rsp_q.push_back({8'h00, ack, d});
      cmd_do(SRA_CMD_WRITE, d, 1'b0);
   endtask

   task automatic stop_frame();
      cmd_do(SRA_CMD_STOP, 8'h00, 1'b0);
      wait_rdy();
      repeat (20) @(negedge sys_clk);
      chk(17'h0, {16'h0, bus_busy});
   endtask

   task automatic wr_frame(input logic [7:0] r, input int n);
      logic [7:0] d;
      cmd_do(SRA_CMD_START, 8'h00, 1'b0);
      wbyte({ADDR_FIXED, lo(), 1'b0}, 1'b1);
      chk(17'h1, {16'h0, bus_busy});
      wbyte(r, 1'b1);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         reg_q.push_back({1'b1, r == FIFO_REG ? r : r + 8'(i), d});
         wbyte(d, 1'b1);
      end
      stop_frame();
   endtask

   task automatic rd_frame(input logic [7:0] r, input int n);
      logic [7:0] a;
      cmd_do(SRA_CMD_START, 8'h00, 1'b0);
      wbyte({ADDR_FIXED, lo(), 1'b0}, 1'b1);
      wbyte(r, 1'b1);
      cmd_do(SRA_CMD_START, 8'h00, 1'b0);
      for (int i = 0; i < n; i++) reg_q.push_back({1'b0, r == FIFO_REG ? r : r + 8'(i), 8'h00});
      wbyte({ADDR_FIXED, lo(), 1'b1}, 1'b1);
      chk(17'h1, {16'h0, bus_busy});
      for (int i = 0; i < n; i++) begin
         a = r == FIFO_REG ? r : r + 8'(i);
         rsp_q.push_back({8'h00, i != n - 1, rdm(a)});
         cmd_do(SRA_CMD_READ, 8'h00, i == n - 1);
      end
      stop_frame();
   endtask

   // every result taken off the oldest note of its queue
   always @(posedge sys_clk) begin
      if (rsp_valid === 1'b1) chk(rsp_q.size() ? rsp_q.pop_front() : 'x, {8'h00, rsp_ack, rsp_data});
      if (reg_wr === 1'b1 || reg_rd === 1'b1) chk(reg_q.size() ? reg_q.pop_front() : 'x, {reg_wr, reg_addr, reg_rd ? 8'h00 : reg_wdata});
   end

   initial begin
      // about 100000 cycles, some margin over the scenarios below
      #800_000;
      miscompares++;
      stop_test();
   end

   initial begin
      logic [7:0] r;
      logic [7:0] bad[4];
      reset = 1'b1;
      short_reach = 1'b0;
      cmd_valid = 1'b0;
      cmd_last = 1'b0;
      cmd = SRA_CMD_START;
      cmd_data = 8'h00;
      rate_sel = RATE_SEL_STD;
      adr_pin = 2'h0;
      adr_cfg = 2'h0;
      adr_use_pin = 1'b0;
      void'($urandom(32'hB228));
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
      repeat (4) @(negedge sys_clk);
      // commands without a start are swallowed, no byte result expected
      cmd_do(SRA_CMD_WRITE, 8'h55, 1'b0);
      cmd_do(SRA_CMD_STOP, 8'h00, 1'b0);
      for (int rs = 0; rs < 4; rs++) begin
         @(negedge sys_clk);
         rate_sel = 2'(rs);
         short_reach = rs == 3;
         adr_use_pin = rs >= 2;
         adr_cfg = 2'($urandom);
         adr_pin = {rs == 3 ? 1'b1 : 1'($urandom), 1'($urandom)};
         r = 8'($urandom_range(8'h10, 8'hC0));
         repeat (10) @(negedge sys_clk);
         if (rs != 1) wr_frame(r, rs == 0 ? 1 : 2);
         if (rs != 0) rd_frame(r, 2);
         if (rs >= 2) begin
            wr_frame(FIFO_REG, 3);
            rd_frame(FIFO_REG, 3);
         end
         // open-drain bus, so a missing acknowledge reads high
         if (rs == 2) begin
            bad = '{{ADDR_FIXED, ~lo(), 1'b0}, 8'h00, 8'hF8, 8'h08};
            foreach (bad[k]) begin
               cmd_do(SRA_CMD_START, 8'h00, 1'b0);
               wbyte(bad[k], 1'b0);
               stop_frame();
            end
         end
      end
      repeat (50) @(negedge sys_clk);
      chk(17'h0, 17'(rsp_q.size() + reg_q.size()));
      stop_test();
   end
endmodule // tb
